// *** rtl/tmr_pkg.sv ***
/*
 Constants, register map and carrier types of the three-mode timer block.
 Assumes a single clock domain and an AXI4-Lite register port with 32-bit data.
*/
`default_nettype none
package tmr_pkg;

	// Register byte offsets
	localparam logic [7:0] TMR_OFF_CTL = 8'h00;
	localparam logic [7:0] TMR_OFF_CNT = 8'h04;
	localparam logic [7:0] TMR_OFF_RA  = 8'h08;
	localparam logic [7:0] TMR_OFF_RB  = 8'h0C;

	// Mode-select codes, order {bit7, bit6, bit5}
	localparam logic [2:0] TMR_MODE_PWM_TGL = 3'h5;
	localparam logic [2:0] TMR_MODE_PWM     = 3'h4;
	localparam logic [2:0] TMR_MODE_EVT_POS = 3'h0;
	localparam logic [2:0] TMR_MODE_EVT_NEG = 3'h1;
	localparam logic [2:0] TMR_MODE_CAP_PP  = 3'h2;
	localparam logic [2:0] TMR_MODE_CAP_PN  = 3'h6;
	localparam logic [2:0] TMR_MODE_CAP_NN  = 3'h3;
	localparam logic [2:0] TMR_MODE_CAP_NN2 = 3'h7;

	// Instruction-cycle divider and its counter width
	localparam int unsigned TMR_TC_DIV_DEF = 10;
	localparam int unsigned TMR_TC_W       = 8;

	localparam logic [1:0] TMR_RESP_OKAY   = 2'h0;
	localparam logic [1:0] TMR_RESP_SLVERR = 2'h2;
	localparam logic [7:0] TMR_CTL_RST     = 8'h00;

	typedef enum logic [2:0] {
		TMR_PWM = 3'b001,
		TMR_EVT = 3'b010,
		TMR_CAP = 3'b100
	} tmr_mode_t;

	// Control byte, bit 7 down to bit 0
	typedef struct packed {
		logic [2:0] mode_sel;
		logic       run_ctl_or_uflow_flag;
		logic       pending_flag_a;
		logic       irq_enable_a;
		logic       pending_flag_b;
		logic       irq_enable_b;
	} tmr_ctl_t;

	typedef struct packed {
		tmr_ctl_t               ctl;
		logic [15:0]            cnt;
		logic [15:0]            reload_capture_reg_a;
		logic [15:0]            reload_capture_reg_b;
		logic [TMR_TC_W-1:0]    tc_cnt;
		logic                   seq_b;
		logic [2:0]             a_sync;
		logic [2:0]             b_sync;
		logic                   a_out;
		logic                   a_oe;
		logic                   irq_a;
		logic                   irq_b;
		logic                   aw_held;
		logic [7:0]             aw_addr;
		logic                   w_held;
		logic [31:0]            w_data;
		logic [3:0]             w_strb;
		logic                   awready;
		logic                   wready;
		logic                   bvalid;
		logic [1:0]             bresp;
		logic                   arready;
		logic                   rvalid;
		logic [31:0]            rdata;
		logic [1:0]             rresp;
	} tmr_state_t;

endpackage
`default_nettype wire

// *** rtl/tmr_block.sv ***
/*
 One 16-bit timer block with two reload/capture registers, PWM, event counter and
 input capture modes, reached over AXI4-Lite.
 Assumes pin inputs are asynchronous and an external wire resolves pin A from its enable.
*/
`timescale 1ns/1ns
`default_nettype none
module tmr_block
	import tmr_pkg::*;
#(
	parameter int unsigned TC_DIV = TMR_TC_DIV_DEF
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output var  logic        awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output var  logic        wready,
	output var  logic [1:0]  bresp,
	output var  logic        bvalid,
	input  wire logic        bready,
	// AXI4-Lite read
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output var  logic        arready,
	output var  logic [31:0] rdata,
	output var  logic [1:0]  rresp,
	output var  logic        rvalid,
	input  wire logic        rready,
	// Timer pins
	input  wire logic        timer_pin_a_in,
	output var  logic        timer_pin_a_out,
	output var  logic        timer_pin_a_oe,
	input  wire logic        timer_pin_b_in,
	// Interrupt requests
	output var  logic        irq_a,
	output var  logic        irq_b
);

	if (TC_DIV < 1 || TC_DIV > 256) begin : g_chk
		$error("TC_DIV must lie in 1..256");
	end

	localparam logic [TMR_TC_W-1:0] TC_LAST = TMR_TC_W'(TC_DIV - 1);

	function automatic tmr_mode_t mode_of(input logic [2:0] sel);
		if (sel[1]) begin
			mode_of = TMR_CAP;
		end else if (sel[2]) begin
			mode_of = TMR_PWM;
		end else begin
			mode_of = TMR_EVT;
		end
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
			input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	tmr_state_t st;
	tmr_state_t next_st;
	tmr_mode_t  mode;
	logic       tick;
	logic       step;
	logic       uflow;
	logic       a_rise;
	logic       a_fall;
	logic       b_rise;
	logic       b_fall;
	logic       cap_a;
	logic       cap_b;
	logic       set_a;
	logic       set_b;
	logic       set_uf;
	logic       wr_now;

	always_comb begin
		next_st = st;
		mode    = mode_of(st.ctl.mode_sel);
		tick    = (st.tc_cnt == '0);
		next_st.tc_cnt = tick ? TC_LAST : st.tc_cnt - 1'b1;
		// Two flops before any logic, third keeps history for edges
		next_st.a_sync = {st.a_sync[1:0], timer_pin_a_in};
		next_st.b_sync = {st.b_sync[1:0], timer_pin_b_in};
		a_rise = st.a_sync[1] & ~st.a_sync[2];
		a_fall = ~st.a_sync[1] & st.a_sync[2];
		b_rise = st.b_sync[1] & ~st.b_sync[2];
		b_fall = ~st.b_sync[1] & st.b_sync[2];
		step   = 1'b0;
		cap_a  = 1'b0;
		cap_b  = 1'b0;
		set_a  = 1'b0;
		set_b  = 1'b0;
		set_uf = 1'b0;
		case (mode)
			TMR_PWM: begin
				step = tick & st.ctl.run_ctl_or_uflow_flag;
			end
			TMR_EVT: begin
				step  = st.ctl.run_ctl_or_uflow_flag &
					(st.ctl.mode_sel[0] ? a_fall : a_rise);
				set_b = b_rise;
			end
			TMR_CAP: begin
				step  = tick;
				cap_a = st.ctl.mode_sel[0] ? a_fall : a_rise;
				cap_b = (st.ctl.mode_sel[2] | st.ctl.mode_sel[0]) ? b_fall : b_rise;
			end
			default: begin
				step = 1'b0;
			end
		endcase
		uflow = step & (st.cnt == 16'h0000);
		// Stopping rearms the reload order so every start begins with A
		if (!st.ctl.run_ctl_or_uflow_flag) begin
			next_st.seq_b = 1'b0;
		end
		if (step) begin
			next_st.cnt = st.cnt - 16'h0001;
			if (uflow && mode == TMR_PWM) begin
				next_st.cnt   = st.seq_b ? st.reload_capture_reg_b
					: st.reload_capture_reg_a;
				next_st.seq_b = ~st.seq_b;
				set_a         = ~st.seq_b;
				set_b         = st.seq_b;
				next_st.a_out = st.a_out ^ st.ctl.mode_sel[0];
			end else if (uflow && mode == TMR_EVT) begin
				next_st.cnt = st.reload_capture_reg_a;
				set_a       = 1'b1;
			end else if (uflow) begin
				set_uf = 1'b1;
			end
		end
		if (cap_a) begin
			next_st.reload_capture_reg_a = st.cnt;
		end
		if (cap_b) begin
			next_st.reload_capture_reg_b = st.cnt;
		end
		set_a = set_a | cap_a;
		set_b = set_b | cap_b;
		// Pin A is only driven while a PWM code is selected
		next_st.a_oe = (mode == TMR_PWM);

		// AXI write: address and data latched independently
		if (awvalid && st.awready) begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = awaddr;
		end
		if (wvalid && st.wready) begin
			next_st.w_held = 1'b1;
			next_st.w_data = wdata;
			next_st.w_strb = wstrb;
		end
		if (st.bvalid && bready) begin
			next_st.bvalid = 1'b0;
		end
		wr_now = st.aw_held & st.w_held & ~st.bvalid;
		if (wr_now) begin
			next_st.aw_held = 1'b0;
			next_st.w_held  = 1'b0;
			next_st.bvalid  = 1'b1;
			next_st.bresp   = TMR_RESP_OKAY;
			// Software data writes win over a count or capture in the same cycle
			case (st.aw_addr)
				TMR_OFF_CTL: begin
					if (st.w_strb[0]) begin
						next_st.ctl = tmr_ctl_t'(st.w_data[7:0]);
					end
				end
				TMR_OFF_CNT: begin
					next_st.cnt = merge16(st.cnt, st.w_data, st.w_strb);
				end
				TMR_OFF_RA: begin
					next_st.reload_capture_reg_a =
						merge16(st.reload_capture_reg_a, st.w_data, st.w_strb);
				end
				TMR_OFF_RB: begin
					next_st.reload_capture_reg_b =
						merge16(st.reload_capture_reg_b, st.w_data, st.w_strb);
				end
				default: begin
					next_st.bresp = TMR_RESP_SLVERR;
				end
			endcase
		end
		// Hardware set wins over a software clear in the same cycle
		next_st.ctl.pending_flag_a = next_st.ctl.pending_flag_a | set_a;
		next_st.ctl.pending_flag_b = next_st.ctl.pending_flag_b | set_b;
		next_st.ctl.run_ctl_or_uflow_flag =
			next_st.ctl.run_ctl_or_uflow_flag | set_uf;
		next_st.awready = ~next_st.aw_held;
		next_st.wready  = ~next_st.w_held;

		// AXI read
		if (st.rvalid && rready) begin
			next_st.rvalid = 1'b0;
		end
		if (arvalid && st.arready) begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = TMR_RESP_OKAY;
			case (araddr)
				TMR_OFF_CTL: next_st.rdata = {24'h00_0000, st.ctl};
				TMR_OFF_CNT: next_st.rdata = {16'h0000, st.cnt};
				TMR_OFF_RA:  next_st.rdata = {16'h0000, st.reload_capture_reg_a};
				TMR_OFF_RB:  next_st.rdata = {16'h0000, st.reload_capture_reg_b};
				default: begin
					next_st.rdata = 32'h0000_0000;
					next_st.rresp = TMR_RESP_SLVERR;
				end
			endcase
		end
		next_st.arready = ~next_st.rvalid;

		// In capture mode the run bit doubles as the A-side underflow flag
		next_st.irq_a = next_st.ctl.irq_enable_a & (next_st.ctl.pending_flag_a |
			(mode_of(next_st.ctl.mode_sel) == TMR_CAP &
			next_st.ctl.run_ctl_or_uflow_flag));
		next_st.irq_b = next_st.ctl.irq_enable_b & next_st.ctl.pending_flag_b;
	end

	// Data registers are cleared too; nothing relies on it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign awready         = st.awready;
	assign wready          = st.wready;
	assign bvalid          = st.bvalid;
	assign bresp           = st.bresp;
	assign arready         = st.arready;
	assign rvalid          = st.rvalid;
	assign rdata           = st.rdata;
	assign rresp           = st.rresp;
	assign timer_pin_a_out = st.a_out;
	assign timer_pin_a_oe  = st.a_oe;
	assign irq_a           = st.irq_a;
	assign irq_b           = st.irq_b;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_uf_from_a;
		mode == TMR_PWM && uflow && !st.seq_b && !wr_now;
	endsequence
	sequence s_uf_from_b;
		mode == TMR_PWM && uflow && st.seq_b && !wr_now;
	endsequence

	pwm_count_down_a: assert property (
		(mode == TMR_PWM && step && st.cnt != 16'h0000 && !wr_now)
		|=> st.cnt == $past(st.cnt) - 16'h0001)
		else $error("PWM counter did not decrement");
	pwm_reload_order_a: assert property (
		s_uf_from_a |=> (st.cnt == $past(st.reload_capture_reg_a) && st.seq_b
		&& st.ctl.pending_flag_a))
		else $error("PWM underflow did not reload from A");
	pwm_reload_b_a: assert property (
		s_uf_from_b |=> (st.cnt == $past(st.reload_capture_reg_b) && st.ctl.pending_flag_b))
		else $error("PWM underflow did not reload from B");
	pwm_toggle_a: assert property (
		(mode == TMR_PWM && uflow)
		|=> timer_pin_a_out == ($past(st.a_out) ^ $past(st.ctl.mode_sel[0])))
		else $error("Pin A toggle wrong on underflow");
	evt_no_drive_a: assert property (
		(mode == TMR_EVT) [*2] |-> !timer_pin_a_oe)
		else $error("Pin A driven in event mode");
	evt_pin_b_a: assert property (
		(mode == TMR_EVT && b_rise) |=> st.ctl.pending_flag_b ##1 irq_b == st.ctl.irq_enable_b)
		else $error("Pin B edge lost in event mode");
	cap_copy_a: assert property (
		(cap_a && !wr_now) |=> (st.reload_capture_reg_a == $past(st.cnt)
		&& st.ctl.pending_flag_a))
		else $error("Capture A missed counter value");
	cap_uflow_a: assert property (
		(mode == TMR_CAP && uflow) |=> st.ctl.run_ctl_or_uflow_flag ##1
		irq_a == st.ctl.irq_enable_a)
		else $error("Capture underflow did not flag");
	stop_hold_a: assert property (
		(mode == TMR_PWM && !st.ctl.run_ctl_or_uflow_flag && !wr_now) |=> $stable(st.cnt))
		else $error("Stopped PWM counter moved");
	bresp_hold_a: assert property (
		(bvalid && !bready) |=> (bvalid && $stable(bresp)))
		else $error("Write response dropped early");

endmodule
`default_nettype wire

// *** tb/tmr_pin_model.sv ***
/*
 Far-side model of the two timer pins: an edge source on pin A and pin B.
 Assumes clk is the block clock and pin A resolves to the device while it drives.
*/
`timescale 1ns/1ns
`default_nettype none
module tmr_pin_model (
	// Clock
	input  wire logic clk,
	// Pins
	input  wire logic a_oe,
	input  wire logic a_out,
	output var  logic a_in,
	output var  logic b_in
);
	logic a_lvl = 1'h0;
	initial b_in = 1'h0;
	// Device owns the wire while enabled
	assign a_in = a_oe ? a_out : a_lvl;
	// Each level held four clocks so the synchroniser sees it
	task automatic pulse(input bit on_b);
		repeat (2) begin
			repeat (4) @(posedge clk);
			if (on_b) b_in <= !b_in;
			else a_lvl <= !a_lvl;
		end
	endtask
endmodule
`default_nettype wire

// *** tb/tmr_block_test.sv ***
/*
 Self-checking bench of the timer block over AXI4-Lite and its pins.
 Assumes TC_DIV of 2 and the pin model on the far side.
*/
`timescale 1ns/1ns
`default_nettype none
module tmr_block_test import tmr_pkg::*;;
	logic        aclk = 1'h0, aresetn;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rd;
	logic [3:0]  wstrb;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, irq_a, irq_b, v;
	logic        pa_out, pa_oe, pa_in, pb_in;
	logic [31:0] rdata;
	logic [1:0]  bresp, rresp, rs;
	int          num_errors = 0, n_tests = 0;
	always #2 aclk = ~aclk;
	tmr_block #(.TC_DIV(2)) u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .timer_pin_a_in(pa_in), .timer_pin_a_out(pa_out),
		.timer_pin_a_oe(pa_oe), .timer_pin_b_in(pb_in), .irq_a(irq_a), .irq_b(irq_b));
	tmr_pin_model u_pins (.clk(aclk), .a_oe(pa_oe), .a_out(pa_out), .a_in(pa_in), .b_in(pb_in));
	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic timeout(input string nm);
		num_errors++;
		$display("[FAIL] %s expected answer seen timeout", nm);
		tally_and_finish();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
		int i;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (i = 0; i < 100; i++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			if (bvalid) break;
		end
		bready <= 1'h0;
		if (i == 100) timeout("bvalid");
	endtask
	task automatic rd_reg(input logic [7:0] a);
		int i;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (i = 0; i < 100; i++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
			if (rvalid) break;
		end
		rready <= 1'h0;
		rd = rdata;
		rs = rresp;
		if (i == 100) timeout("rvalid");
	endtask
	// Bound covers a full B period plus bus traffic
	task automatic wait_irq(input bit b);
		int i;
		for (i = 0; i < 2000 && (b ? irq_b : irq_a) !== 1'h1; i++) @(posedge aclk);
		if (i == 2000) timeout("irq");
	endtask
	task automatic t_bus();
		rd_reg(TMR_OFF_CTL);
		check("ctl reset", {24'h00_0000, TMR_CTL_RST}, rd);
		rd_reg(8'h10);
		check("unmapped resp", TMR_RESP_SLVERR, rs);
		check("unmapped data", 32'h0000_0000, rd);
		wr(TMR_OFF_CTL, 32'h0000_00B0, 4'hE);
		rd_reg(TMR_OFF_CTL);
		check("ctl no strobe", 32'h0000_0000, rd);
		$display("test bus done");
	endtask
	task automatic t_pwm();
		wr(TMR_OFF_RA, 32'h0000_0014);
		wr(TMR_OFF_RB, 32'h0000_0028);
		wr(TMR_OFF_CNT, 32'h0000_0000);
		wr(TMR_OFF_CTL, {24'h00_0000, TMR_MODE_PWM_TGL, 5'h14});
		wait_irq(0);
		check("pin a oe", 1'h1, pa_oe);
		check("pin a first", 1'h1, pa_out);
		rd_reg(TMR_OFF_CTL);
		check("pend first", 2'h2, {rd[3], rd[1]});
		rd_reg(TMR_OFF_CNT);
		check("load from a", 1'h1, rd[15:0] <= 16'h0014);
		check("irq b gated", 1'h0, irq_b);
		wr(TMR_OFF_CTL, {24'h00_0000, TMR_MODE_PWM_TGL, 5'h15});
		check("irq a cleared", 1'h0, irq_a);
		wait_irq(1);
		check("pin a second", 1'h0, pa_out);
		wr(TMR_OFF_CTL, {24'h00_0000, TMR_MODE_PWM, 5'h14});
		v = pa_out;
		wait_irq(0);
		check("no toggle", v, pa_out);
		wr(TMR_OFF_CTL, 32'h0000_0000);
		$display("test pwm done");
	endtask
	task automatic t_event();
		wr(TMR_OFF_CNT, 32'h0000_0002);
		wr(TMR_OFF_RA, 32'h0000_0007);
		wr(TMR_OFF_CTL, {24'h00_0000, TMR_MODE_EVT_POS, 5'h15});
		check("oe event", 1'h0, pa_oe);
		u_pins.pulse(0);
		u_pins.pulse(0);
		check("no early uflow", 1'h0, irq_a);
		u_pins.pulse(0);
		wait_irq(0);
		rd_reg(TMR_OFF_CNT);
		check("event reload", 32'h0000_0007, rd);
		u_pins.pulse(1);
		wait_irq(1);
		rd_reg(TMR_OFF_CTL);
		check("event pend", 2'h3, {rd[3], rd[1]});
		$display("test event done");
	endtask
	task automatic t_cap();
		wr(TMR_OFF_CTL, 32'h0000_0000);
		wr(TMR_OFF_RA, 32'h0000_1234);
		wr(TMR_OFF_CNT, 32'h0000_0000);
		// Run bit left clear when entering capture
		wr(TMR_OFF_CTL, {24'h00_0000, TMR_MODE_CAP_PP, 5'h04});
		wait_irq(0);
		rd_reg(TMR_OFF_CTL);
		check("uflow flag", 2'h2, {rd[4], rd[3]});
		wr(TMR_OFF_CTL, {24'h00_0000, TMR_MODE_CAP_PP, 5'h05});
		u_pins.pulse(0);
		wait_irq(0);
		rd_reg(TMR_OFF_RA);
		check("capture a", 1'h1, rd[15:0] > 16'hFF00);
		u_pins.pulse(1);
		wait_irq(1);
		rd_reg(TMR_OFF_RB);
		check("capture b", 1'h1, rd[15:0] > 16'hFF00);
		$display("test capture done");
	endtask
	initial begin
		// Idle bus levels set here so no instance input starts out as a fixed tie
		aresetn = 1'h0;
		awaddr  = 8'h00;
		araddr  = 8'h00;
		wdata   = 32'h0000_0000;
		wstrb   = 4'h0;
		awvalid = 1'h0;
		wvalid  = 1'h0;
		bready  = 1'h0;
		arvalid = 1'h0;
		rready  = 1'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		t_bus();
		t_pwm();
		t_event();
		t_cap();
		tally_and_finish();
	end
endmodule
`default_nettype wire
